// ==== core/sac_pkg.sv ====
package sac_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_RESULT_HIGH = 16'hFFC4;
   localparam logic [15:0] IDX_RESULT_LOW = 16'hFFC5;
   localparam logic [15:0] IDX_MODE = 16'hFFC6;
   localparam logic [15:0] IDX_START = 16'hFFC7;
   localparam logic [15:0] IDX_CLOCK_STOP = 16'hFFFA;
   localparam logic [15:0] IDX_EDGE_SEL = 16'hFFC8;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFC9;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hFFCA;
   localparam int ADDR_W = 18;

   // reset values
   localparam logic [7:0] MODE_RST = 8'h30;
   localparam logic [7:0] CLOCK_STOP_RST = 8'hFF;
   localparam logic [1:0] MODE_RSVD_ONES = 2'h3;
   localparam logic [6:0] START_RSVD_ONES = 7'h7F;

   // field positions
   localparam int MODE_SPEED_BIT = 7;
   localparam int MODE_TRIG_BIT = 6;
   localparam int START_FLAG_BIT = 7;
   localparam int STANDBY_BIT = 4;

   // conversion timing in system clock cycles
   localparam logic [5:0] PERIOD_SLOW = 6'h3E;
   localparam logic [5:0] PERIOD_FAST = 6'h1F;
   localparam logic [2:0] SAMPLE_SLOW = 3'h2;
   localparam logic [2:0] SAMPLE_FAST = 3'h1;
   localparam logic [2:0] STEP_SLOW = 3'h6;
   localparam logic [2:0] STEP_FAST = 3'h3;
   localparam int RES_W = 10;
   localparam int NUM_CH = 8;

   typedef enum logic [2:0] {
      SAC_IDLE = 3'b001,
      SAC_SAMPLE = 3'b010,
      SAC_CONVERT = 3'b100
   } sac_state_t;
endpackage : sac_pkg

// ==== core/sac_top.sv ====
// What this block does
// R1 - result kept as 10 bits: top 8 in high register, low 2 in low bits 7:6
// R2 - results readable anytime; held unchanged until the next conversion finishes
// R3 - reset does not touch the two result registers
// R4 - reset sets mode register to 30 hex
// R5 - mode bit 7 picks period: 0 gives 62 cycles, 1 gives 31 cycles
// R6 - software keeps conversion time at 12.4 microseconds or longer
// R7 - mode bit 6 enables start by external trigger edge; else edges ignored
// R8 - trigger edge polarity chosen by a separate edge select bit
// R9 - mode bits 5:4 and start bits 6:0 read as one, writes ignored
// R10 - channel field: 00xx none, 01xx inputs 0 to 3, 10xx inputs 4 to 7
// R11 - software changes channel only while start flag reads zero
// R12 - writing 1 to start flag starts; trigger start also sets the flag
// R13 - on completion results load and start flag clears together
// R14 - writing 0 to start flag stops a running conversion; an enabled trigger edge in the same cycle overrides the stop
// R15 - start flag reads 1 while busy, 0 when done; reset clears it
// R16 - eight selectable inputs and 10 bit resolution
// R17 - clock stop bit 4 low puts converter in standby; reset value releases
// R18 - completion sets end request flag; interrupt only when its enable is 1
// R19 - count the selected cycles from start before completing
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sac_top
   import sac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_trigger_pin,
   input wire logic comp_above,
   output logic [NUM_CH-1:0] input_select,
   output logic sample_hold,
   output logic [RES_W-1:0] dac_code,
   output logic converter_standby,
   output logic irq
);

   function automatic logic [NUM_CH-1:0] decode_channel(input logic [3:0] field);
      logic [NUM_CH-1:0] onehot;
      onehot = '0;
      case (field[3:2])
         2'b01: onehot[{1'b0, field[1:0]}] = 1'b1;
         2'b10: onehot[{1'b1, field[1:0]}] = 1'b1;
         default: onehot = '0;
      endcase
      return onehot;
   endfunction : decode_channel

   function automatic logic [5:0] period_m1(input logic fast);
      return fast ? PERIOD_FAST - 6'h1 : PERIOD_SLOW - 6'h1;
   endfunction : period_m1

   // register state
   logic speed_select_ff;
   logic ext_trigger_enable_ff;
   logic [3:0] input_select_field_ff;
   logic start_flag_ff;
   logic [7:0] module_clock_stop_reg_one_ff;
   logic trigger_edge_select_ff;
   logic conv_end_request_ff;
   logic conv_end_irq_enable_ff;
   logic [7:0] conv_result_high_ff;
   logic [1:0] conv_result_low_ff;

   // bus state
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   // conversion state
   sac_state_t state_ff;
   logic [2:0] phase_cnt_ff;
   logic [3:0] bit_idx_ff;
   logic [RES_W-1:0] trial_ff;
   logic [NUM_CH-1:0] input_select_ff;
   logic sample_hold_ff;
   logic standby_ff;
   logic irq_ff;

   // synchronisers
   logic trig_meta_ff;
   logic trig_sync_ff;
   logic trig_prev_ff;
   logic comp_meta_ff;
   logic comp_sync_ff;

   // ---------------- bus decode ----------------
   wire [15:0] word_idx = paddr[ADDR_W-1:2];
   wire access = psel & penable & pready_ff;
   wire wr = access & pwrite;
   wire rd = access & ~pwrite;
   wire hit_high = word_idx == IDX_RESULT_HIGH;
   wire hit_low = word_idx == IDX_RESULT_LOW;
   wire hit_mode = word_idx == IDX_MODE;
   wire hit_start = word_idx == IDX_START;
   wire hit_stop = word_idx == IDX_CLOCK_STOP;
   wire hit_edge = word_idx == IDX_EDGE_SEL;
   wire hit_status = word_idx == IDX_IRQ_STATUS;
   wire hit_mask = word_idx == IDX_IRQ_MASK;
   wire mapped = (hit_high | hit_low | hit_mode | hit_start | hit_stop | hit_edge
                  | hit_status | hit_mask) & (paddr[1:0] == 2'h0);

   wire [7:0] mode_rd = {speed_select_ff, ext_trigger_enable_ff, MODE_RSVD_ONES,
                         input_select_field_ff}; // R9
   wire [7:0] start_rd = {start_flag_ff, START_RSVD_ONES}; // R9 R15
   wire [7:0] low_rd = {conv_result_low_ff, 6'h00}; // R1
   wire [7:0] rd_byte = hit_high ? conv_result_high_ff :
                        hit_low ? low_rd :
                        hit_mode ? mode_rd :
                        hit_start ? start_rd :
                        hit_stop ? module_clock_stop_reg_one_ff :
                        hit_edge ? {7'h00, trigger_edge_select_ff} :
                        hit_status ? {7'h00, conv_end_request_ff} :
                        hit_mask ? {7'h00, conv_end_irq_enable_ff} : 8'h00;

   // one wait state: pready rises in the second access cycle
   wire nxt_pready = psel & penable & ~pready_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pready & ~mapped;
         prdata_ff <= (nxt_pready & ~pwrite & mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ---------------- software controls ----------------
   wire mode_wr = wr & hit_mode & mapped;
   wire start_wr = wr & hit_start & mapped;
   wire sw_start = start_wr & pwdata[START_FLAG_BIT]; // R12
   wire sw_stop = start_wr & ~pwdata[START_FLAG_BIT]; // R14
   wire standby = ~module_clock_stop_reg_one_ff[STANDBY_BIT]; // R17

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         speed_select_ff <= MODE_RST[MODE_SPEED_BIT]; // R4
         ext_trigger_enable_ff <= MODE_RST[MODE_TRIG_BIT]; // R4
         input_select_field_ff <= MODE_RST[3:0]; // R4
         module_clock_stop_reg_one_ff <= CLOCK_STOP_RST;
         trigger_edge_select_ff <= 1'b0;
         conv_end_irq_enable_ff <= 1'b0;
      end else begin
         if (mode_wr) begin
            speed_select_ff <= pwdata[MODE_SPEED_BIT];
            ext_trigger_enable_ff <= pwdata[MODE_TRIG_BIT];
            input_select_field_ff <= pwdata[3:0];
         end
         if (wr & hit_stop & mapped) begin
            module_clock_stop_reg_one_ff <= pwdata[7:0];
         end
         if (wr & hit_edge & mapped) begin
            trigger_edge_select_ff <= pwdata[0]; // R8
         end
         if (wr & hit_mask & mapped) begin
            conv_end_irq_enable_ff <= pwdata[0];
         end
      end
   end

   // ---------------- external trigger ----------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trig_meta_ff <= 1'b0;
         trig_sync_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
         comp_meta_ff <= 1'b0;
         comp_sync_ff <= 1'b0;
      end else begin
         trig_meta_ff <= ext_trigger_pin;
         trig_sync_ff <= trig_meta_ff;
         trig_prev_ff <= trig_sync_ff;
         comp_meta_ff <= comp_above;
         comp_sync_ff <= comp_meta_ff;
      end
   end

   // edge select 1 means rising, 0 means falling
   wire trig_edge = trigger_edge_select_ff ? (trig_sync_ff & ~trig_prev_ff)
                                           : (~trig_sync_ff & trig_prev_ff); // R8
   wire hw_start = trig_edge & ext_trigger_enable_ff; // R7 R12

   // ---------------- conversion sequencer ----------------
   wire idle = state_ff == SAC_IDLE;
   wire [2:0] sample_last = speed_select_ff ? SAMPLE_FAST - 3'h1 : SAMPLE_SLOW - 3'h1; // R5
   wire [2:0] step_last = speed_select_ff ? STEP_FAST - 3'h1 : STEP_SLOW - 3'h1; // R5
   // a start while busy is dropped; the trigger wins over a same-cycle stop
   wire go = idle & ~standby & (sw_start | hw_start); // R12
   wire abort = ~idle & ((sw_stop & ~hw_start) | standby); // R14 R17
   wire decide = (state_ff == SAC_CONVERT) & (phase_cnt_ff == step_last);
   wire done = decide & (bit_idx_ff == 4'h0) & ~abort; // R19

   logic [RES_W-1:0] sar_next;
   always_comb begin
      sar_next = trial_ff;
      // comparator low means the trial overshoots, so drop this bit
      sar_next[bit_idx_ff] = comp_sync_ff;
      if (bit_idx_ff != 4'h0) begin
         sar_next[bit_idx_ff - 4'h1] = 1'b1;
      end
   end

   sac_state_t nxt_state;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SAC_IDLE: begin
            if (go) begin
               nxt_state = SAC_SAMPLE;
            end
         end
         SAC_SAMPLE: begin
            if (abort) begin
               nxt_state = SAC_IDLE;
            end else if (phase_cnt_ff == sample_last) begin
               nxt_state = SAC_CONVERT;
            end
         end
         SAC_CONVERT: begin
            if (abort | done) begin
               nxt_state = SAC_IDLE;
            end
         end
         default: nxt_state = SAC_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff <= SAC_IDLE;
         phase_cnt_ff <= 3'h0;
         bit_idx_ff <= 4'h0;
         trial_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff || decide) begin
            phase_cnt_ff <= 3'h0;
         end else begin
            phase_cnt_ff <= phase_cnt_ff + 3'h1;
         end
         if (state_ff == SAC_SAMPLE && nxt_state == SAC_CONVERT) begin
            bit_idx_ff <= 4'(RES_W - 1); // R16
            trial_ff <= {1'b1, {(RES_W - 1){1'b0}}};
         end else if (decide) begin
            bit_idx_ff <= bit_idx_ff - 4'h1;
            trial_ff <= sar_next;
         end
      end
   end

   // start flag: set by start, cleared by completion, stop or standby
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start_flag_ff <= 1'b0; // R15
      end else if (go) begin
         start_flag_ff <= 1'b1; // R12 R15
      end else if (done | abort) begin
         start_flag_ff <= 1'b0; // R13 R14
      end
   end

   // results carry no reset so a reset leaves the last value readable
   always_ff @(posedge clk) begin
      if (done) begin
         conv_result_high_ff <= sar_next[RES_W-1:2]; // R1 R2 R3 R13
         conv_result_low_ff <= sar_next[1:0]; // R1
      end
   end

   // ---------------- interrupt ----------------
   wire status_rd = rd & hit_status & mapped;
   wire nxt_request = done | (conv_end_request_ff & ~status_rd); // R18
   wire nxt_enable = (wr & hit_mask & mapped) ? pwdata[0] : conv_end_irq_enable_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conv_end_request_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         conv_end_request_ff <= nxt_request; // R18
         irq_ff <= nxt_request & nxt_enable; // R18
      end
   end

   // ---------------- analog side outputs ----------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         input_select_ff <= '0;
         sample_hold_ff <= 1'b0;
         standby_ff <= 1'b0;
      end else begin
         input_select_ff <= decode_channel(input_select_field_ff); // R10 R16
         sample_hold_ff <= nxt_state == SAC_SAMPLE;
         standby_ff <= standby; // R17
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign input_select = input_select_ff;
   assign sample_hold = sample_hold_ff;
   assign dac_code = trial_ff;
   assign converter_standby = standby_ff;
   assign irq = irq_ff;

   // ---------------- checks ----------------
   logic [5:0] elapsed_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         elapsed_ff <= 6'h0;
      end else if (idle) begin
         elapsed_ff <= 6'h0;
      end else begin
         elapsed_ff <= elapsed_ff + 6'h1;
      end
   end

   result_load_a: assert property (@(posedge clk) disable iff (reset) // R1
      done |=> conv_result_high_ff == $past(sar_next[RES_W-1:2])
               && conv_result_low_ff == $past(sar_next[1:0]) && !start_flag_ff)
      else $error("result not loaded or flag not cleared at completion");

   // identity compare: results are unknown until the first completion after power-up
   result_hold_a: assert property (@(posedge clk) disable iff (reset) // R2
      !done |=> conv_result_high_ff === $past(conv_result_high_ff)
                && conv_result_low_ff === $past(conv_result_low_ff))
      else $error("result changed without a completion");

   reserved_ones_a: assert property (@(posedge clk) disable iff (reset) // R9
      psel && penable && pready_ff && !pwrite && mapped && (hit_mode || hit_start)
      |-> (hit_mode ? prdata_ff[5:4] == 2'h3 : prdata_ff[6:0] == 7'h7F))
      else $error("reserved bits do not read as one");

   conv_period_a: assert property (@(posedge clk) disable iff (reset) // R5
      done |-> elapsed_ff == period_m1(speed_select_ff))
      else $error("conversion did not take the selected period");

   trig_ignored_a: assert property (@(posedge clk) disable iff (reset) // R7
      idle && trig_edge && !ext_trigger_enable_ff && !sw_start |=> !start_flag_ff)
      else $error("disabled trigger started a conversion");

   trig_start_a: assert property (@(posedge clk) disable iff (reset) // R12
      idle && hw_start && !standby |=> start_flag_ff && state_ff == SAC_SAMPLE)
      else $error("enabled trigger edge did not start");

   sw_abort_a: assert property (@(posedge clk) disable iff (reset) // R14
      !idle && sw_stop && !hw_start |=> !start_flag_ff && idle)
      else $error("stop write did not end the conversion");

   chan_decode_a: assert property (@(posedge clk) disable iff (reset) // R10
      ##1 input_select_ff == decode_channel($past(input_select_field_ff)))
      else $error("channel select mismatch");

   flag_busy_a: assert property (@(posedge clk) disable iff (reset) // R15
      start_flag_ff == !idle)
      else $error("start flag does not track conversion");

   standby_stop_a: assert property (@(posedge clk) disable iff (reset) // R17
      standby |=> idle && !start_flag_ff)
      else $error("converter ran during standby");

   irq_level_a: assert property (@(posedge clk) disable iff (reset) // R18
      done |=> conv_end_request_ff && (irq_ff == conv_end_irq_enable_ff))
      else $error("end request or interrupt wrong after completion");

endmodule : sac_top
`default_nettype wire

// ==== bench/sac_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
(
   input wire logic [NUM_CH-1:0] input_select,
   input wire logic [RES_W-1:0] dac_code,
   input wire logic [NUM_CH*RES_W-1:0] levels,
   output logic comp_above
);
   // with no input on the mux the comparator sees ground and never keeps a bit
   always_comb begin
      comp_above = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (input_select[i]) begin
            comp_above = levels[i*RES_W+:RES_W] >= dac_code;
         end
      end
   end
endmodule : sac_analog_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sac_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic trig = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [NUM_CH*RES_W-1:0] levels = '0;
   logic [31:0] prdata;
   logic pready, pslverr, comp_above, sample_hold, standby, irq;
   logic [NUM_CH-1:0] input_select;
   logic [RES_W-1:0] dac_code;
   logic [RES_W-1:0] lvl;
   logic [17:0] e;
   logic [17:0] expq[$];
   int fail_count = 0;
   int samples_checked = 0;

   always #20 clk = ~clk;

   sac_top uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_trigger_pin(trig), .comp_above(comp_above), .input_select(input_select),
      .sample_hold(sample_hold), .dac_code(dac_code), .converter_standby(standby), .irq(irq));

   sac_analog_model model (.input_select(input_select), .dac_code(dac_code), .levels(levels),
      .comp_above(comp_above));

   task stop_test;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // the note is queued before the request so the monitor always finds it
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [7:0] m,
            input logic err);
      int n;
      expq.push_back({w, err, m, d});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         stop_test();
      end
   endtask : apb

   task wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 8'h00, 1'b0);
   endtask : wr

   task rd(input logic [15:0] idx, input logic [7:0] d, input logic [7:0] m = 8'hFF);
      apb(1'b0, idx, d, m, 1'b0);
   endtask : rd

   task idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : idle

   task wait_irq(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irq !== 1'b1 && n < 200);
      if (n >= 200) begin
         fail_count++;
         stop_test();
      end
   endtask : wait_irq

   task conv(input logic fast, input int ch);
      int n;
      lvl = 10'($urandom);
      levels[ch*RES_W+:RES_W] <= lvl;
      // both speeds run short of the minimum time at this clock; the ideal model still gives exact results, which are checked
      wr(IDX_MODE, {fast, 3'b011, ch[2] ? 2'b10 : 2'b01, ch[1:0]});
      wr(IDX_START, 8'h80);
      #1 chk(sample_hold, 1'b1);
      wait_irq(n);
      chk(n, fast ? 31 : 62);
      rd(IDX_START, 8'h7F);
      rd(IDX_RESULT_HIGH, lvl[9:2]);
      rd(IDX_RESULT_LOW, {lvl[1:0], 6'h00}, 8'hC0);
      rd(IDX_IRQ_STATUS, 8'h01, 8'h01);
      rd(IDX_IRQ_STATUS, 8'h00, 8'h01);
      chk(irq, 1'b0);
   endtask : conv

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         e = expq.pop_front();
         chk(pslverr, e[16]);
         if (!e[17]) chk({prdata[31:8], prdata[7:0] & e[15:8]}, {24'h0, e[7:0] & e[15:8]});
      end
   end

   initial begin
      int n;
      n = $urandom(29109);
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd(IDX_MODE, MODE_RST);
      rd(IDX_START, 8'h7F);
      rd(IDX_CLOCK_STOP, 8'hFF);
      apb(1'b0, 16'h0001, 8'h00, 8'hFF, 1'b1);
      wr(IDX_MODE, 8'hC5);
      rd(IDX_MODE, 8'hF5);
      wr(IDX_START, 8'h00);
      rd(IDX_START, 8'h7F);
      for (int f = 0; f < 16; f++) begin
         wr(IDX_MODE, 8'(f));
         idle(1);
         chk(input_select, f[3:2] == 2'b01 ? 8'h01 << f[1:0] :
             f[3:2] == 2'b10 ? 8'h10 << f[1:0] : 8'h00);
      end
      wr(IDX_IRQ_MASK, 8'h01);
      for (n = 0; n < NUM_CH; n++) conv(n[0], n);
      // completion with the interrupt masked still latches the request
      wr(IDX_IRQ_MASK, 8'h00);
      wr(IDX_START, 8'h80);
      idle(70);
      chk(irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      idle(2);
      chk(irq, 1'b1);
      rd(IDX_IRQ_STATUS, 8'h01, 8'h01);
      wr(IDX_RESULT_HIGH, 8'h00);
      rd(IDX_RESULT_HIGH, lvl[9:2]);
      wr(IDX_START, 8'h80);
      idle(10);
      wr(IDX_START, 8'h00);
      rd(IDX_START, 8'h7F);
      idle(70);
      rd(IDX_IRQ_STATUS, 8'h00, 8'h01);
      rd(IDX_RESULT_HIGH, lvl[9:2]);
      wr(IDX_EDGE_SEL, 8'h01);
      trig <= 1'b1;
      idle(6);
      rd(IDX_START, 8'h7F);
      wr(IDX_MODE, 8'h4B);
      trig <= 1'b0;
      idle(6);
      rd(IDX_START, 8'h7F);
      trig <= 1'b1;
      idle(6);
      rd(IDX_START, 8'hFF);
      wr(IDX_START, 8'h00);
      wr(IDX_EDGE_SEL, 8'h00);
      trig <= 1'b0;
      idle(6);
      rd(IDX_START, 8'hFF);
      wr(IDX_START, 8'h00);
      wr(IDX_CLOCK_STOP, 8'hEF);
      idle(1);
      chk(standby, 1'b1);
      wr(IDX_START, 8'h80);
      rd(IDX_START, 8'h7F);
      rd(IDX_CLOCK_STOP, 8'hEF);
      wr(IDX_CLOCK_STOP, 8'hFF);
      idle(2);
      chk(standby, 1'b0);
      reset <= 1'b1;
      idle(2);
      reset <= 1'b0;
      rd(IDX_RESULT_HIGH, lvl[9:2]);
      rd(IDX_RESULT_LOW, {lvl[1:0], 6'h00}, 8'hC0);
      rd(IDX_MODE, MODE_RST);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
